// file: logic/sews_device.sv
// EEPROM slave end: decodes the two-wire link and programs the array.
// Assumes one 40 MHz clock; the serial pins are asynchronous to it.
//
// How it works
// - Three strap pins select one of eight addresses.
// - Open strap pins read as low.
// - Data line is open-drain, released reads high.
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
// - Stop during read returns to standby.
// - Stop during write launches the write cycle.
// - Data changes only while clock is low.
// - Eight bits, then receiver acknowledges on ninth.
// - Busy device ignores bus and never acknowledges.
// - Address matches type code and straps, then acknowledge.
// - Byte write: address, two address bytes, data, stop.
// - Page write accepts up to 32 data bytes.
// - Only low five address bits increment and wrap.
// - Page bits stay fixed; small variant ignores top.
// - Program from start address, received bytes only.
// - Protect pin high blocks every memory write.
// - Protected data bytes are not acknowledged.
// - Master holds protect level from start to stop.
// - Array starts with every byte erased high.
`timescale 1ns/1ps
`default_nettype none
module sews_device #(
  parameter int WRITE_CYCLES = sews_pkg::WRITE_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  sews_if.device bus,
  input wire logic [12:0] peek_addr_i,
  output logic [7:0] peek_data_o,
  output logic busy_o
);
  typedef enum logic [2:0] {DV_IDLE, DV_RX, DV_ACK, DV_IGNORE, DV_READ, DV_PROG, DV_WAIT} sews_dev_state_t;
  typedef enum logic [1:0] {KIND_DEV, KIND_HI, KIND_LO, KIND_DATA} sews_kind_t;

  sews_dev_state_t state, next_state, after, next_after;
  sews_kind_t kind, next_kind;
  logic [3:0] bits, next_bits;
  logic [7:0] sh, next_sh;
  logic [12:0] addr, next_addr;
  logic [7:0] page_buf [sews_pkg::PAGE_BYTES];
  logic [7:0] next_page_buf [sews_pkg::PAGE_BYTES];
  logic [31:0] valid, next_valid;
  logic [4:0] prog_idx, next_idx;
  logic [31:0] wait_cnt, next_wait;
  logic oe, next_oe;
  logic [7:0] mem [sews_pkg::MEM_BYTES];
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic wp_m, wp_s;
  logic [2:0] strap_m, strap_s;
  logic start, stop, scl_rise, scl_fall;

  // ----------------------------------------
  // Pin synchronisers and condition detect
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      wp_m <= 1'b0;
      wp_s <= 1'b0;
      strap_m <= 3'h0;
      strap_s <= 3'h0;
    end else begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= bus.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      wp_m <= bus.wp;
      wp_s <= wp_m;
      strap_m <= bus.strap;
      strap_s <= strap_m;
    end
  end

  // A data change with the clock high is never a data bit.
  assign start = scl_s && scl_d && sda_d && !sda_s;
  assign stop = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;

  // The device never drives high; releasing the line lets the pull-up win.
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe;

  // ----------------------------------------
  // Protocol and write-cycle sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_after = after;
    next_kind = kind;
    next_bits = bits;
    next_sh = sh;
    next_addr = addr;
    next_page_buf = page_buf;
    next_valid = valid;
    next_idx = prog_idx;
    next_wait = wait_cnt;
    next_oe = oe;
    case (state)
      // While programming, start, stop and clocks are all ignored.
      DV_PROG: begin
        next_idx = prog_idx + 5'h01;
        if (prog_idx == 5'h1f) begin
          next_state = DV_WAIT;
          next_wait = 32'h0000_0000;
        end
      end
      DV_WAIT: begin
        if (wait_cnt >= 32'(WRITE_CYCLES - 1)) begin
          next_state = DV_IDLE;
          next_valid = 32'h0000_0000;
        end else begin
          next_wait = wait_cnt + 32'h0000_0001;
        end
      end
      default: begin
        if (start) begin
          next_state = DV_RX;
          next_kind = KIND_DEV;
          next_bits = 4'h0;
          next_oe = 1'b0;
          next_valid = 32'h0000_0000;
        end else if (stop) begin
          next_oe = 1'b0;
          next_idx = 5'h00;
          // A read, an unmatched address or a dummy write just goes idle.
          if (kind == KIND_DATA && valid != 32'h0000_0000) begin
            next_state = DV_PROG;
          end else begin
            next_state = DV_IDLE;
          end
        end else begin
          case (state)
            DV_RX: begin
              if (scl_rise && bits != sews_pkg::BITS_PER_BYTE) begin
                next_sh = {sh[6:0], sda_s};
                next_bits = bits + 4'h1;
              end else if (scl_fall && bits == sews_pkg::BITS_PER_BYTE) begin
                next_state = DV_ACK;
                next_after = DV_RX;
                next_oe = 1'b1;
                case (kind)
                  KIND_DEV: begin
                    if (sh[7:4] == sews_pkg::DEV_CODE && sh[3:1] == strap_s) begin
                      next_kind = KIND_HI;
                      next_after = sh[0] ? DV_READ : DV_RX;
                    end else begin
                      next_state = DV_IGNORE;
                      next_oe = 1'b0;
                    end
                  end
                  KIND_HI: begin
                    next_addr[12:8] = sh[4:0] & sews_pkg::ADDR_HI_MASK;
                    next_kind = KIND_LO;
                  end
                  KIND_LO: begin
                    next_addr[7:0] = sh;
                    next_kind = KIND_DATA;
                  end
                  default: begin
                    if (wp_s) begin
                      next_oe = 1'b0;
                    end else begin
                      // Buffer slots follow the low address bits, so a long page overwrites itself.
                      next_page_buf[addr[4:0]] = sh;
                      next_valid[addr[4:0]] = 1'b1;
                      next_addr[4:0] = addr[4:0] + 5'h01;
                    end
                  end
                endcase
              end
            end
            DV_ACK: begin
              if (scl_fall) begin
                next_oe = 1'b0;
                next_bits = 4'h0;
                next_state = after;
              end
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= DV_IDLE;
      after <= DV_RX;
      kind <= KIND_DEV;
      bits <= 4'h0;
      sh <= 8'h00;
      addr <= 13'h0000;
      valid <= 32'h0000_0000;
      prog_idx <= 5'h00;
      wait_cnt <= 32'h0000_0000;
      oe <= 1'b0;
      busy_o <= 1'b0;
      for (int i = 0; i < sews_pkg::PAGE_BYTES; i++) begin
        page_buf[i] <= 8'h00;
      end
    end else begin
      state <= next_state;
      after <= next_after;
      kind <= next_kind;
      bits <= next_bits;
      sh <= next_sh;
      addr <= next_addr;
      valid <= next_valid;
      prog_idx <= next_idx;
      wait_cnt <= next_wait;
      oe <= next_oe;
      busy_o <= (next_state == DV_PROG) || (next_state == DV_WAIT);
      page_buf <= next_page_buf;
    end
  end

  // ----------------------------------------
  // Array
  // ----------------------------------------
  // Programming walks all 32 slots so the cycle length never depends on data.
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < sews_pkg::MEM_BYTES; i++) begin
        mem[i] <= sews_pkg::ERASED_BYTE;
      end
      peek_data_o <= 8'h00;
    end else begin
      if (state == DV_PROG && valid[prog_idx]) begin
        mem[{addr[12:5], prog_idx}] <= page_buf[prog_idx];
      end
      peek_data_o <= mem[peek_addr_i];
    end
  end
endmodule : sews_device
`default_nettype wire

// file: logic/sews_host.sv
// Bus master end: issues byte and page writes over the two-wire link.
// Assumes one 40 MHz clock; the serial clock is made here by a divider.
`timescale 1ns/1ps
`default_nettype none
module sews_host (
  input wire logic clock_i,
  input wire logic reset_i,
  sews_if.host bus,
  input wire logic go_i,
  input wire logic [2:0] dev_sel_i,
  input wire logic [15:0] word_addr_i,
  input wire logic [5:0] count_i,
  input wire logic [7:0] data_i,
  input wire logic data_valid_i,
  output logic data_ready_o,
  output logic busy_o,
  output logic done_o,
  output logic nack_o
);
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_XFER, HS_STOP} sews_host_state_t;

  sews_host_state_t state, next_state;
  logic [7:0] div, next_div;
  logic tick;
  logic [1:0] q, next_q;
  logic [3:0] bitn, next_bitn;
  logic [5:0] bi, next_bi;
  logic [7:0] sh, next_sh;
  logic [2:0] dev, next_dev;
  logic [15:0] addr, next_addr;
  logic [5:0] cnt, next_cnt;
  logic scl, next_scl;
  logic oe, next_oe;
  logic next_ready, next_done, next_nack;
  logic sda_m, sda_s;

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= bus.sda;
      sda_s <= sda_m;
    end
  end

  assign tick = (div == 8'(sews_pkg::QUARTER_CYCLES - 1));
  assign bus.scl = scl;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = oe;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_div = tick ? 8'h00 : div + 8'h01;
    next_q = q;
    next_bitn = bitn;
    next_bi = bi;
    next_sh = sh;
    next_dev = dev;
    next_addr = addr;
    next_cnt = cnt;
    next_scl = scl;
    next_oe = oe;
    next_ready = 1'b0;
    next_done = 1'b0;
    next_nack = nack_o;
    case (state)
      HS_IDLE: begin
        next_div = 8'h00;
        if (go_i) begin
          next_state = HS_START;
          next_q = 2'h0;
          next_dev = dev_sel_i;
          next_addr = word_addr_i;
          next_cnt = count_i;
          next_nack = 1'b0;
        end
      end
      HS_START: if (tick) begin
        next_q = q + 2'h1;
        case (q)
          2'h0: next_scl = 1'b1;
          // Data falls while the clock is high.
          2'h1: next_oe = 1'b1;
          2'h2: next_scl = 1'b0;
          default: begin
            next_state = HS_XFER;
            next_bitn = 4'h0;
            next_bi = 6'h00;
            next_sh = {sews_pkg::DEV_CODE, dev, 1'b0};
          end
        endcase
      end
      HS_XFER: if (tick) begin
        next_q = q + 2'h1;
        case (q)
          // Data changes only while the clock is low.
          2'h0: next_oe = (bitn != sews_pkg::BITS_PER_BYTE) && !sh[7];
          2'h1: next_scl = 1'b1;
          2'h2: if (bitn == sews_pkg::BITS_PER_BYTE) begin
            next_nack = sda_s;
          end
          default: begin
            next_scl = 1'b0;
            if (bitn != sews_pkg::BITS_PER_BYTE) begin
              next_sh = {sh[6:0], 1'b0};
              next_bitn = bitn + 4'h1;
            end else if (nack_o || bi == 6'h02 + cnt) begin
              next_state = HS_STOP;
              next_q = 2'h0;
            end else if (bi >= 6'h02 && !data_valid_i) begin
              // Hold the clock high until the next data byte arrives.
              next_q = q;
              next_scl = scl;
            end else begin
              next_bi = bi + 6'h01;
              next_bitn = 4'h0;
              next_ready = (bi >= 6'h02);
              next_sh = (bi == 6'h00) ? addr[15:8] : (bi == 6'h01) ? addr[7:0] : data_i;
            end
          end
        endcase
      end
      default: if (tick) begin
        next_q = q + 2'h1;
        case (q)
          2'h0: next_oe = 1'b1;
          2'h1: next_scl = 1'b1;
          // Data rises while the clock is high.
          2'h2: next_oe = 1'b0;
          default: begin
            next_state = HS_IDLE;
            next_done = 1'b1;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= HS_IDLE;
      div <= 8'h00;
      q <= 2'h0;
      bitn <= 4'h0;
      bi <= 6'h00;
      sh <= 8'h00;
      dev <= 3'h0;
      addr <= 16'h0000;
      cnt <= 6'h00;
      scl <= 1'b1;
      oe <= 1'b0;
      data_ready_o <= 1'b0;
      done_o <= 1'b0;
      nack_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      q <= next_q;
      bitn <= next_bitn;
      bi <= next_bi;
      sh <= next_sh;
      dev <= next_dev;
      addr <= next_addr;
      cnt <= next_cnt;
      scl <= next_scl;
      oe <= next_oe;
      data_ready_o <= next_ready;
      done_o <= next_done;
      nack_o <= next_nack;
      busy_o <= (next_state != HS_IDLE);
    end
  end
endmodule : sews_host
`default_nettype wire

// file: logic/sews_if.sv
// Two-wire link between the bus master and the EEPROM slave.
// The bench drives strap and protect pins; open pins read low.
`timescale 1ns/1ps
`default_nettype none
interface sews_if;
  logic scl;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic sda;
  logic [2:0] strap_val;
  logic [2:0] strap_en;
  logic [2:0] strap;
  logic wp_val;
  logic wp_en;
  logic wp;

  // Open-drain wire with pull-up: any enabled driver pulling low wins.
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));
  // Undriven strap and protect pins fall to low through their pull-downs.
  assign strap = strap_val & strap_en;
  assign wp = wp_val & wp_en;

  modport device (input scl, input sda, input strap, input wp, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface : sews_if
`default_nettype wire

// file: logic/sews_pkg.sv
// Constants shared by both ends of the two-wire serial EEPROM write link.
// Assumes a single 40 MHz system clock on each end.
`default_nettype none
package sews_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_NS = 5000000;
  // Longest time, so the count rounds down.
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int SCL_QUARTER_NS = 625;
  // Least time, so the count rounds up.
  localparam int QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Addressing and array
  // ----------------------------------------
  // Device type code; the value is arbitrary.
  localparam logic [3:0] DEV_CODE = 4'h6;
  localparam logic SMALL_VARIANT = 1'b0;
  localparam logic [4:0] ADDR_HI_MASK = SMALL_VARIANT ? 5'h0f : 5'h1f;
  localparam int MEM_BYTES = 8192;
  localparam int PAGE_BYTES = 32;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : sews_pkg
`default_nettype wire

// file: sim/sews_link_asserts.sv
// Concurrent checks on the two-wire link between bus master and EEPROM slave.
// Assumes the interface signals and the shared 40 MHz clock and reset.
`timescale 1ns/1ps
`default_nettype none
module sews_link_asserts (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic host_sda_oe,
  input wire logic [2:0] strap,
  input wire logic wp
);
  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  logic scl_q, sda_q, in_frame, matched;
  logic [3:0] bit_cnt;
  logic [7:0] byte_cnt, shreg, oe_len;
  logic start_seen, stop_seen, ack_slot;
  assign start_seen = scl & scl_q & sda_q & ~sda;
  assign stop_seen = scl & scl_q & ~sda_q & sda;
  assign ack_slot = scl & ~scl_q & (bit_cnt == 4'h8);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      matched <= 1'b0;
      bit_cnt <= 4'h0;
      byte_cnt <= 8'h00;
      shreg <= 8'h00;
      oe_len <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      oe_len <= !dev_sda_oe ? 8'h00 : (oe_len == 8'hff ? oe_len : oe_len + 8'h01);
      if (start_seen) begin
        in_frame <= 1'b1;
        matched <= 1'b0;
        bit_cnt <= 4'h0;
        byte_cnt <= 8'h00;
      end else if (stop_seen) begin
        in_frame <= 1'b0;
        matched <= 1'b0;
      end else if (ack_slot) begin
        bit_cnt <= 4'h0;
        byte_cnt <= (byte_cnt == 8'hff) ? byte_cnt : byte_cnt + 8'h01;
        if (byte_cnt == 8'h00) begin
          matched <= (shreg[7:1] == {sews_pkg::DEV_CODE, strap});
        end
      end else if (scl & ~scl_q) begin
        bit_cnt <= bit_cnt + 4'h1;
        shreg <= {shreg[6:0], sda};
      end
    end
  end

  // ----------------------------------------
  // Assertions and cover points
  // ----------------------------------------
  a_oe_scl_low: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("slave data line moved while clock high");
  a_ack_hold_high: assert property ($rose(scl) && dev_sda_oe |-> (dev_sda_oe && scl)[*8])
    else $error("slave acknowledge dropped during clock high");
  a_ack_release: assert property ($fell(scl) && dev_sda_oe |-> ##[1:8] !dev_sda_oe)
    else $error("slave acknowledge not released after ninth clock");
  a_ack_one_slot: assert property ($fell(dev_sda_oe) |-> $past(oe_len) >= 8'h5a && $past(oe_len) <= 8'h6e)
    else $error("slave acknowledge length outside one bit slot");
  a_addr_match: assert property (ack_slot && byte_cnt == 8'h00 && dev_sda_oe |->
    shreg[7:1] == {sews_pkg::DEV_CODE, strap}) else $error("address acknowledged without match");
  a_wp_no_ack: assert property (ack_slot && in_frame && wp && byte_cnt >= 8'h03 |-> !dev_sda_oe)
    else $error("data byte acknowledged while protected");
  a_oe_after_start: assert property (dev_sda_oe |-> in_frame)
    else $error("slave drove line outside a frame");
  a_oe_needs_match: assert property (dev_sda_oe && byte_cnt != 8'h00 |-> matched)
    else $error("unaddressed slave drove line");
  a_host_free_ack: assert property (ack_slot && in_frame |-> !host_sda_oe)
    else $error("master pulled line in acknowledge slot");
  c_addr_ack: cover property (ack_slot && in_frame && byte_cnt == 8'h00 && dev_sda_oe);
  c_data_ack: cover property (ack_slot && in_frame && byte_cnt > 8'h22 && dev_sda_oe);
  c_wp_block: cover property (ack_slot && in_frame && wp && byte_cnt == 8'h03);
endmodule : sews_link_asserts
`default_nettype wire

// file: sim/tb_serial_eeprom_write_slave.sv
// Self-checking bench joining the master and slave ends through the link interface.
// Assumes the package, interface and both design modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_write_slave;
  // Short write wait, long enough to still be busy when the next address byte arrives.
  localparam int WCYC = 2000;
  localparam int LOW0 = 28;
  logic clock_i, reset_i, go_i, data_valid_i, data_ready_o, host_busy, done_o, nack_o, dev_busy;
  logic [2:0] dev_sel_i;
  logic [15:0] word_addr_i;
  logic [5:0] count_i;
  logic [7:0] data_i, peek_data_o;
  logic [12:0] peek_addr_i;
  int error_cnt;
  int tests_run;

  sews_if i_sews_if ();
  sews_host i_sews_host (.clock_i(clock_i), .reset_i(reset_i), .bus(i_sews_if), .go_i(go_i),
    .dev_sel_i(dev_sel_i), .word_addr_i(word_addr_i), .count_i(count_i), .data_i(data_i),
    .data_valid_i(data_valid_i), .data_ready_o(data_ready_o), .busy_o(host_busy), .done_o(done_o),
    .nack_o(nack_o));
  sews_device #(.WRITE_CYCLES(WCYC)) i_sews_device (.clock_i(clock_i), .reset_i(reset_i),
    .bus(i_sews_if), .peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o), .busy_o(dev_busy));
  sews_link_asserts chk (.clock_i(clock_i), .reset_i(reset_i), .scl(i_sews_if.scl), .sda(i_sews_if.sda),
    .dev_sda_oe(i_sews_if.dev_sda_oe), .host_sda_oe(i_sews_if.host_sda_oe), .strap(i_sews_if.strap),
    .wp(i_sews_if.wp));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_write(input logic [2:0] sel, input logic [15:0] addr, input logic [5:0] cnt,
    input logic [7:0] d0);
    int n;
    logic took;
    n = 0;
    took = 1'b0;
    @(posedge clock_i);
    #2;
    dev_sel_i = sel;
    word_addr_i = addr;
    count_i = cnt;
    data_i = d0;
    go_i = 1'b1;
    @(posedge clock_i);
    #2;
    go_i = 1'b0;
    check({7'h00, host_busy}, 8'h01);
    while (done_o !== 1'b1 && n < 40000) begin
      @(posedge clock_i);
      #2;
      if (took) data_i = data_i + 8'h01;
      took = (data_ready_o === 1'b1);
      n++;
    end
    check({7'h00, done_o}, 8'h01);
    check({7'h00, host_busy}, 8'h00);
  endtask : do_write

  task automatic dev_busy_len(output int cyc);
    int n;
    n = 0;
    cyc = 0;
    while (dev_busy !== 1'b1 && n < 40) begin
      @(posedge clock_i);
      #2;
      n++;
    end
    while (dev_busy === 1'b1 && cyc < 3 * WCYC) begin
      @(posedge clock_i);
      #2;
      cyc++;
    end
  endtask : dev_busy_len

  task automatic peek(input logic [12:0] a, input logic [7:0] exp);
    peek_addr_i = a;
    @(posedge clock_i);
    @(posedge clock_i);
    #2;
    check(peek_data_o, exp);
  endtask : peek

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset_state();
    peek(13'h0000, sews_pkg::ERASED_BYTE);
    peek(13'h1fff, sews_pkg::ERASED_BYTE);
    check({7'h00, i_sews_if.sda}, 8'h01);
    $display("test reset_state done");
  endtask : test_reset_state

  task automatic test_byte_write();
    int c;
    do_write(3'h5, 16'h1234, 6'h01, 8'ha5);
    check({7'h00, nack_o}, 8'h00);
    dev_busy_len(c);
    // Busy spans the 32-cycle walk plus the wait; about 22 of those cycles pass before done.
    check({7'h00, c >= WCYC + 6 && c <= WCYC + 14}, 8'h01);
    peek(13'h1234, 8'ha5);
    peek(13'h1235, sews_pkg::ERASED_BYTE);
    $display("test byte_write done");
  endtask : test_byte_write

  task automatic test_page_wrap();
    int c;
    int k;
    // Top three address bits are set to show that they do not reach the array.
    do_write(3'h5, 16'hff3c, 6'h22, 8'h40);
    check({7'h00, nack_o}, 8'h00);
    do_write(3'h5, 16'h0000, 6'h01, 8'h11);
    check({7'h00, nack_o}, 8'h01);
    dev_busy_len(c);
    for (int s = 0; s < 32; s++) begin
      k = (s - LOW0 + 32) % 32;
      if (k < 2) k += 32;
      peek({8'hf9, s[4:0]}, 8'(8'h40 + k));
    end
    peek(13'h1f1f, sews_pkg::ERASED_BYTE);
    peek(13'h1f40, sews_pkg::ERASED_BYTE);
    peek(13'h0000, sews_pkg::ERASED_BYTE);
    $display("test page_wrap done");
  endtask : test_page_wrap

  task automatic test_protect();
    int c;
    // Protect level only moves between frames.
    i_sews_if.wp_val = 1'b1;
    i_sews_if.wp_en = 1'b1;
    do_write(3'h5, 16'h0100, 6'h02, 8'h3c);
    check({7'h00, nack_o}, 8'h01);
    dev_busy_len(c);
    check({7'h00, c == 0}, 8'h01);
    peek(13'h0100, sews_pkg::ERASED_BYTE);
    i_sews_if.wp_en = 1'b0;
    do_write(3'h5, 16'h0100, 6'h01, 8'h3c);
    check({7'h00, nack_o}, 8'h00);
    dev_busy_len(c);
    peek(13'h0100, 8'h3c);
    $display("test protect done");
  endtask : test_protect

  task automatic test_straps();
    for (int s = 0; s < 8; s++) begin
      i_sews_if.strap_val = s[2:0];
      do_write(s[2:0], 16'h0000, 6'h00, 8'h00);
      check({7'h00, nack_o}, 8'h00);
    end
    // Open strap pins must read low whatever level was last applied.
    i_sews_if.strap_val = 3'h7;
    i_sews_if.strap_en = 3'h0;
    do_write(3'h7, 16'h0000, 6'h00, 8'h00);
    check({7'h00, nack_o}, 8'h01);
    do_write(3'h0, 16'h0000, 6'h00, 8'h00);
    check({7'h00, nack_o}, 8'h00);
    $display("test straps done");
  endtask : test_straps

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  initial begin
    repeat (100000) @(posedge clock_i);
    error_cnt++;
    $display("[ERR] t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    error_cnt = 0;
    tests_run = 0;
    reset_i = 1'b1;
    go_i = 1'b0;
    dev_sel_i = 3'h0;
    word_addr_i = 16'h0000;
    count_i = 6'h00;
    data_i = 8'h00;
    data_valid_i = 1'b1;
    peek_addr_i = 13'h0000;
    i_sews_if.strap_val = 3'h5;
    i_sews_if.strap_en = 3'h7;
    i_sews_if.wp_val = 1'b0;
    i_sews_if.wp_en = 1'b0;
    repeat (2) @(posedge clock_i);
    #2;
    reset_i = 1'b0;
    test_reset_state();
    test_byte_write();
    test_page_wrap();
    test_protect();
    test_straps();
    tally_and_finish();
  end
endmodule : tb_serial_eeprom_write_slave
`default_nettype wire
